// ---- ufbc_pkg.sv ----
// register map, field positions, codes and reset values of the serial port
`default_nettype none

package ufbc_pkg;

   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam int ADDR_W = 3;
   localparam logic [2:0] A_DATA = 3'h0;
   localparam logic [2:0] A_CTRL_A = 3'h1;
   localparam logic [2:0] A_CTRL_B = 3'h2;
   localparam logic [2:0] A_CTRL_C = 3'h3;
   localparam logic [2:0] A_BAUD_LO = 3'h4;
   localparam logic [2:0] A_BAUD_HI = 3'h5;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int A_TXC = 6;
   localparam int A_U2X = 1;
   localparam int A_MPCM = 0;
   localparam int B_RXEN = 4;
   localparam int B_TXEN = 3;
   localparam int B_SZ2 = 2;
   localparam int B_TX8 = 0;
   localparam int C_MODE_HI = 7;
   localparam int C_MODE_LO = 6;
   localparam int C_PAR_HI = 5;
   localparam int C_PAR_LO = 4;
   localparam int C_STOP = 3;
   localparam int C_SZ_HI = 2;
   localparam int C_SZ_LO = 1;
   localparam int C_POL = 0;

   // ------------------------------------------------------------
   // reset values and widths
   // ------------------------------------------------------------
   localparam logic [7:0] B_RESET = 8'h00;
   localparam logic [7:0] C_RESET = 8'h06;
   localparam int BAUD_W = 12;
   localparam int RXQ_DEPTH = 2;

   // ------------------------------------------------------------
   // codes
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      MODE_ASYNC = 2'h0,
      MODE_SYNC = 2'h1,
      MODE_RSVD = 2'h2,
      MODE_SPI = 2'h3
   } ufbc_mode_t;
   localparam logic [2:0] CHAR_SZ5 = 3'h0;
   localparam logic [2:0] CHAR_SZ6 = 3'h1;
   localparam logic [2:0] CHAR_SZ7 = 3'h2;
   localparam logic [2:0] CHAR_SZ8 = 3'h3;
   localparam logic [2:0] CHAR_SZ9 = 3'h7;
   localparam logic [3:0] OS16_LAST = 4'hF;
   localparam logic [3:0] OS16_MID = 4'h7;
   localparam logic [3:0] OS8_LAST = 4'h7;
   localparam logic [3:0] OS8_MID = 4'h3;
   localparam logic [3:0] RX_SH_W = 4'hA;

endpackage

`default_nettype wire

// ---- ufbc_baud_if.sv ----
// divider value, reload strobe and rate tick between control and prescaler
`default_nettype none

interface ufbc_baud_if #(parameter int W = ufbc_pkg::BAUD_W);
   logic reload;
   logic [W-1:0] divisor;
   logic tick;
   modport ctl (output reload, output divisor, input tick);
   modport gen (input reload, input divisor, output tick);
endinterface

`default_nettype wire

// ---- ufbc_baud_gen.sv ----
// baud-rate prescaler: one tick every divisor plus one clocks
`default_nettype none

module ufbc_baud_gen #(
   parameter int W = ufbc_pkg::BAUD_W
) (
   input wire logic clk,
   input wire logic rstn,
   ufbc_baud_if.gen bus
);
   import ufbc_pkg::*;

   logic [W-1:0] cnt_q;
   logic tick_q;

   assign bus.tick = tick_q;

   // R17 immediate reload
   always_ff @(posedge clk) begin
      if (!rstn) begin
         cnt_q <= '0;
         tick_q <= 1'b0;
      end else if (bus.reload) begin
         cnt_q <= bus.divisor;
         tick_q <= 1'b0;
      end else if (cnt_q == '0) begin
         cnt_q <= bus.divisor;
         tick_q <= 1'b1;
      end else begin
         cnt_q <= cnt_q - 1'b1;
         tick_q <= 1'b0;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   reload_a: assert property (bus.reload |=> cnt_q == $past(bus.divisor) // R17
      && !tick_q)
      else $error("prescaler not reloaded at once");

endmodule // ufbc_baud_gen

`default_nettype wire

// ---- ufbc_top.sv ----
// serial port frame, baud and control logic with its register file
//
// The register addresses and the strobed register port are this design's own decisions.
`default_nettype none

// ---------------------------------------------------------------
// Notes on behaviour
// R1 - receiver enable claims the receive pin
// R2 - receiver disable flushes buffer and error flags
// R3 - transmitter enable claims transmit pin, disable releases
// R4 - transmitter disable waits until nothing left to send
// R5 - software reads ninth bit before low byte
// R6 - software writes ninth bit before low byte
// R7 - mode field: async, sync, reserved, master spi
// R8 - parity field: off, reserved, even, odd
// R9 - transmitter appends parity bit to every frame; the code appends it only while parity is even or odd
// R10 - receiver checks parity, flags mismatch
// R11 - stop select gives one or two transmit stops
// R12 - three size bits give five to nine bits
// R13 - sync polarity chooses change and sample edges
// R14 - software keeps polarity zero in async mode
// R15 - twelve-bit divider split high nibble, low byte
// R16 - software writes zeros to reserved divider bits
// R17 - low divider write reloads the prescaler
// R18 - software avoids rate change during transfers
// R19 - double speed cuts oversampling sixteen to eight
// R20 - bit rate is clock over ratio times divider+1
// ---------------------------------------------------------------

module ufbc_top #(
   parameter int RXQ_D = ufbc_pkg::RXQ_DEPTH
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [ufbc_pkg::ADDR_W-1:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output var logic [7:0] rdata_q,
   input wire logic receive_pin,
   input wire logic external_sync_clock_pin,
   output var logic transmit_pin_q,
   output var logic transmit_pin_oe_q,
   output var logic receive_pin_owned_q
);
   import ufbc_pkg::*;

   localparam int PW = $clog2(RXQ_D);

   typedef enum logic [1:0] {
      TX_IDLE = 2'b01,
      TX_SHIFT = 2'b10
   } ufbc_tx_state_t;
   typedef enum logic [3:0] {
      RX_IDLE = 4'b0001,
      RX_START = 4'b0010,
      RX_DATA = 4'b0100,
      RX_STOP = 4'b1000
   } ufbc_rx_state_t;

   // ------------------------------------------------------------
   // register file
   // ------------------------------------------------------------
   logic [7:0] b_q, c_q;
   logic u2x_q, mpcm_q, txc_q, dor_q;
   logic [BAUD_W-1:0] baud_q;
   wire wr_data = wr && addr == A_DATA;
   wire wr_lo = wr && addr == A_BAUD_LO;
   logic txc_set;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         b_q <= B_RESET;
         c_q <= C_RESET;
         u2x_q <= 1'b0;
         mpcm_q <= 1'b0;
         baud_q <= '0;
      end else if (wr) begin
         case (addr)
            A_CTRL_A: begin
               u2x_q <= wdata[A_U2X];
               mpcm_q <= wdata[A_MPCM];
            end
            A_CTRL_B: b_q <= wdata;
            A_CTRL_C: c_q <= wdata;
            // R15 divider halves
            A_BAUD_LO: baud_q[7:0] <= wdata;
            A_BAUD_HI: baud_q[BAUD_W-1:8] <= wdata[BAUD_W-9:0];
            default: ;
         endcase
      end
   end

   // set wins over the write-one clear
   always_ff @(posedge clk) begin
      if (!rstn) txc_q <= 1'b0;
      else if (txc_set) txc_q <= 1'b1;
      else if (wr && addr == A_CTRL_A && wdata[A_TXC]) txc_q <= 1'b0;
   end

   // ------------------------------------------------------------
   // decoded settings
   // ------------------------------------------------------------
   // R7 mode select
   wire ufbc_mode_t mode = ufbc_mode_t'(c_q[C_MODE_HI:C_MODE_LO]);
   wire is_async = mode == MODE_ASYNC;
   wire is_sync = mode == MODE_SYNC;
   // master spi and reserved modes keep both shifters idle
   wire frames_on = is_async || is_sync;
   // R8 parity select; reserved code behaves as disabled
   wire par_en = c_q[C_PAR_HI];
   wire par_odd = c_q[C_PAR_LO];
   wire two_stop = c_q[C_STOP];
   wire [2:0] sz = {b_q[B_SZ2], c_q[C_SZ_HI:C_SZ_LO]};
   logic [3:0] nbits;
   // R12 character size; reserved codes fall back to eight
   always_comb begin
      case (sz)
         CHAR_SZ5: nbits = 4'h5;
         CHAR_SZ6: nbits = 4'h6;
         CHAR_SZ7: nbits = 4'h7;
         CHAR_SZ8: nbits = 4'h8;
         CHAR_SZ9: nbits = 4'h9;
         default: nbits = 4'h8;
      endcase
   end
   wire [3:0] k = nbits + {3'h0, par_en};
   // R19 oversampling ratio
   wire [3:0] osr_last = u2x_q ? OS8_LAST : OS16_LAST;
   wire [3:0] osr_mid = u2x_q ? OS8_MID : OS16_MID;

   // ------------------------------------------------------------
   // prescaler
   // ------------------------------------------------------------
   ufbc_baud_if bif ();
   // R17 reload with the value being written
   assign bif.reload = wr_lo;
   assign bif.divisor = wr_lo ? {baud_q[BAUD_W-1:8], wdata} : baud_q;
   ufbc_baud_gen #(.W(BAUD_W)) u_baud (
      .clk(clk),
      .rstn(rstn),
      .bus(bif.gen)
   );

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic [2:0] rx_s_q, xk_s_q;
   logic rx_f_q, xk_f_q;
   always_ff @(posedge clk) begin
      if (!rstn) begin
         rx_s_q <= 3'h7;
         xk_s_q <= 3'h0;
         rx_f_q <= 1'b1;
         xk_f_q <= 1'b0;
      end else begin
         rx_s_q <= {rx_s_q[1:0], receive_pin};
         xk_s_q <= {xk_s_q[1:0], external_sync_clock_pin};
         if (rx_s_q[2] == rx_s_q[1]) rx_f_q <= rx_s_q[1];
         if (xk_s_q[2] == xk_s_q[1]) xk_f_q <= xk_s_q[1];
      end
   end
   wire xk_chg = xk_s_q[2] == xk_s_q[1] && xk_s_q[1] != xk_f_q;
   // R13 edge choice by polarity
   wire tx_edge = xk_chg && (xk_s_q[1] != c_q[C_POL]);
   wire rx_edge = xk_chg && (xk_s_q[1] == c_q[C_POL]);

   // ------------------------------------------------------------
   // transmitter
   // ------------------------------------------------------------
   ufbc_tx_state_t tx_st_q;
   logic [12:0] tx_frame_q;
   logic [3:0] tx_left_q, tx_os_q;
   logic [8:0] tx_buf_q;
   logic tx_full_q;
   wire tx_load = tx_st_q == TX_IDLE && tx_full_q && transmit_pin_oe_q
      && frames_on;
   // R20 bit period of ratio times divider+1 clocks
   wire tx_step = is_sync ? tx_edge : bif.tick && tx_os_q == osr_last;
   wire [3:0] tx_len = 4'h2 + nbits + {3'h0, par_en} + {3'h0, two_stop};
   wire [12:0] pmask = (13'h1 << (nbits + 4'h2)) - 13'h2;
   assign txc_set = tx_st_q == TX_SHIFT && tx_step && tx_left_q == 4'h1
      && !tx_full_q;

   // start, data, optional parity, then stop ones
   function automatic logic [12:0] build(input logic [8:0] d,
      input logic [3:0] n, input logic pe, input logic po);
      logic [12:0] f;
      logic p;
      f = '1;
      f[0] = 1'b0;
      p = po;
      for (int i = 0; i < 9; i++) begin
         if (i < int'(n)) begin
            f[i+1] = d[i];
            p = p ^ d[i];
         end
      end
      if (pe) f[n+4'h1] = p;
      return f;
   endfunction

   always_ff @(posedge clk) begin
      if (!rstn) begin
         tx_buf_q <= '0;
         tx_full_q <= 1'b0;
      end else if (wr_data && !tx_full_q) begin
         // R6 ninth bit taken from its control bit now
         tx_buf_q <= {b_q[B_TX8], wdata};
         tx_full_q <= 1'b1;
      end else if (tx_load) begin
         tx_full_q <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn || tx_load) tx_os_q <= '0;
      else if (bif.tick) tx_os_q <= tx_os_q == osr_last ? '0 : tx_os_q + 4'h1;
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         tx_st_q <= TX_IDLE;
         tx_frame_q <= '1;
         tx_left_q <= '0;
      end else begin
         case (tx_st_q)
            TX_IDLE: begin
               if (tx_load) begin
                  // R9 R11 parity and stop bits in the frame
                  tx_frame_q <= build(tx_buf_q, nbits, par_en, par_odd);
                  tx_left_q <= tx_len;
                  tx_st_q <= TX_SHIFT;
               end
            end
            TX_SHIFT: begin
               if (tx_step) begin
                  tx_frame_q <= {1'b1, tx_frame_q[12:1]};
                  tx_left_q <= tx_left_q - 4'h1;
                  if (tx_left_q == 4'h1) tx_st_q <= TX_IDLE;
               end
            end
            default: tx_st_q <= TX_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         transmit_pin_q <= 1'b1;
         transmit_pin_oe_q <= 1'b0;
      end else begin
         transmit_pin_q <= tx_st_q == TX_SHIFT ? tx_frame_q[0] : 1'b1;
         // R3 R4 pin held until shifter and buffer drain
         transmit_pin_oe_q <= b_q[B_TXEN] || (transmit_pin_oe_q
            && (tx_st_q == TX_SHIFT || tx_full_q));
      end
   end

   // ------------------------------------------------------------
   // receiver
   // ------------------------------------------------------------
   ufbc_rx_state_t rx_st_q;
   logic [3:0] rx_os_q, rx_n_q;
   logic [9:0] rx_sh_q;
   wire rx_en = b_q[B_RXEN];
   wire [3:0] rx_tgt = rx_st_q == RX_START ? osr_mid : osr_last;
   wire rx_samp = is_sync ? rx_edge : bif.tick && rx_os_q == rx_tgt;
   wire rx_push = rx_st_q == RX_STOP && rx_samp;
   wire [9:0] rx_al = rx_sh_q >> (RX_SH_W - k);
   wire [8:0] rx_dat = rx_al[8:0] & ~(9'h1FF << nbits);
   // R10 parity check against the selected sense
   wire rx_pe = par_en && ^{rx_dat, rx_al[nbits], par_odd};
   wire [10:0] rx_ent = {!rx_f_q, rx_pe, rx_dat};

   always_ff @(posedge clk) begin
      if (!rstn) receive_pin_owned_q <= 1'b0;
      // R1 receive pin claimed
      else receive_pin_owned_q <= rx_en;
   end

   always_ff @(posedge clk) begin
      if (!rstn || !rx_en || !frames_on) begin
         rx_st_q <= RX_IDLE;
         rx_os_q <= '0;
         rx_n_q <= '0;
         rx_sh_q <= '0;
      end else begin
         if (rx_st_q == RX_IDLE || rx_samp) rx_os_q <= '0;
         else if (bif.tick) rx_os_q <= rx_os_q + 4'h1;
         case (rx_st_q)
            RX_IDLE: begin
               rx_n_q <= '0;
               if (!rx_f_q && is_async) rx_st_q <= RX_START;
               else if (!rx_f_q && rx_edge) rx_st_q <= RX_DATA;
            end
            // false start if line is high again at mid bit
            RX_START: if (rx_samp) rx_st_q <= rx_f_q ? RX_IDLE : RX_DATA;
            RX_DATA: begin
               if (rx_samp) begin
                  rx_sh_q <= {rx_f_q, rx_sh_q[9:1]};
                  rx_n_q <= rx_n_q + 4'h1;
                  if (rx_n_q == k - 4'h1) rx_st_q <= RX_STOP;
               end
            end
            RX_STOP: if (rx_samp) rx_st_q <= RX_IDLE;
            default: rx_st_q <= RX_IDLE;
         endcase
      end
   end

   // two-level receive queue of {frame err, parity err, data}
   logic [10:0] rxq_q [RXQ_D];
   logic [PW-1:0] rxq_wp_q, rxq_rp_q;
   logic [PW:0] rxq_cnt_q;
   wire rxq_has = rxq_cnt_q != '0;
   wire rxq_full = rxq_cnt_q == (PW+1)'(RXQ_D);
   wire rxq_pop = rd && addr == A_DATA && rxq_has;
   wire rxq_in = rx_push && !rxq_full;
   wire [10:0] head = rxq_q[rxq_rp_q];

   always_ff @(posedge clk) begin
      if (rxq_in) rxq_q[rxq_wp_q] <= rx_ent;
   end

   always_ff @(posedge clk) begin
      // R2 flush on receiver disable
      if (!rstn || !rx_en) begin
         rxq_wp_q <= '0;
         rxq_rp_q <= '0;
         rxq_cnt_q <= '0;
         dor_q <= 1'b0;
      end else begin
         if (rxq_in) rxq_wp_q <= rxq_wp_q + 1'b1;
         if (rxq_pop) rxq_rp_q <= rxq_rp_q + 1'b1;
         rxq_cnt_q <= rxq_cnt_q + (PW+1)'(rxq_in) - (PW+1)'(rxq_pop);
         if (rx_push && rxq_full) dor_q <= 1'b1;
         else if (rxq_pop) dor_q <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // read port: data only in the cycle after the strobe
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rstn || !rd) rdata_q <= 8'h00;
      else begin
         case (addr)
            A_DATA: rdata_q <= rxq_has ? head[7:0] : 8'h00;
            A_CTRL_A: rdata_q <= {rxq_has, txc_q, !tx_full_q,
               rxq_has & head[10], dor_q, rxq_has & head[9], u2x_q, mpcm_q};
            // R5 ninth bit of the unread head character
            A_CTRL_B: rdata_q <= {b_q[7:2], rxq_has & head[8], b_q[B_TX8]};
            A_CTRL_C: rdata_q <= c_q;
            A_BAUD_LO: rdata_q <= baud_q[7:0];
            A_BAUD_HI: rdata_q <= {4'h0, baud_q[BAUD_W-1:8]};
            default: rdata_q <= 8'h00;
         endcase
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   sequence tx_drain_s;
      tx_st_q == TX_SHIFT || tx_full_q;
   endsequence

   rx_own_a: assert property ($rose(rx_en) |=> receive_pin_owned_q) // R1
      else $error("receive pin not claimed");
   rx_flush_a: assert property (!rx_en |=> !rxq_has && !dor_q) // R2
      else $error("receive queue not flushed");
   tx_release_a: assert property (!b_q[B_TXEN] && tx_st_q != TX_SHIFT // R3
      && !tx_full_q |=> !transmit_pin_oe_q)
      else $error("transmit pin not released");
   tx_hold_a: assert property (transmit_pin_oe_q ##0 tx_drain_s // R4
      |=> transmit_pin_oe_q)
      else $error("transmitter released with data pending");
   tx_parity_a: assert property (tx_load && par_en // R9
      |=> (^(tx_frame_q & pmask)) == $past(par_odd))
      else $error("wrong parity bit");
   stop_len_a: assert property (tx_load && two_stop && !par_en // R11
      && nbits == 4'h8 |=> tx_left_q == 4'hB)
      else $error("wrong frame length");
   size_a: assert property (sz == CHAR_SZ9 |-> nbits == 4'h9) // R12
      else $error("nine-bit size not decoded");
   sync_edge_a: assert property (is_sync && tx_step // R13
      |-> xk_s_q[1] == !c_q[C_POL])
      else $error("transmit changed on wrong edge");
   dbl_speed_a: assert property (is_async && u2x_q // R19
      && tx_st_q == TX_SHIFT |-> tx_os_q <= OS8_LAST)
      else $error("double speed ratio not eight");

endmodule // ufbc_top

`default_nettype wire

// ---- ufbc_remote.sv ----
// remote serial port model facing the transmit and receive pins
`default_nettype none

module ufbc_remote (
   input wire logic clk,
   output var logic line_out,
   input wire logic line_in
);
   timeunit 1ns;
   timeprecision 100ps;

   // line idles high between frames, like a pulled-up wire
   initial line_out = 1'b1;

   // sends n bits lsb first, bt clocks each
   task automatic send(input logic [13:0] f, input int n, input int bt);
      for (int i = 0; i < n; i++) begin
         line_out <= f[i];
         repeat (bt) @(posedge clk);
      end
      line_out <= 1'b1;
   endtask

   // samples n bits at mid-bit after a falling edge; bounded wait
   task automatic grab(input int n, input int bt, output logic [13:0] f,
         output logic ok);
      int w;
      f = '1;
      ok = 1'b0;
      w = 0;
      while (line_in === 1'b1 && w < 4000) begin
         @(posedge clk);
         w++;
      end
      if (w < 4000) begin
         ok = 1'b1;
         repeat (bt / 2) @(posedge clk);
         for (int i = 0; i < n; i++) begin
            f[i] = line_in;
            if (i < n - 1) repeat (bt) @(posedge clk);
         end
      end
   endtask
endmodule // ufbc_remote

`default_nettype wire

// ---- tb_top.sv ----
// self-checking bench for the serial port control block
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import ufbc_pkg::*;

   logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, xck = 1'b0;
   logic [2:0] addr = 3'h0;
   logic [7:0] wdata = 8'h00, rdata_q, d;
   logic rx_line, tx_pin, tx_oe, rx_own, ok;
   logic [13:0] got, exp;
   logic [8:0] dv [2];
   logic [2:0] szc [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
   logic [1:0] pcs [5] = '{2'h0, 2'h2, 2'h3, 2'h1, 2'h2};
   logic [7:0] rst_v [8] = '{8'h00, 8'h20, 8'h00, 8'h06, 8'h00, 8'h00,
      8'h00, 8'h00};
   logic [1:0] pc;
   integer seed = 32'h8ed4_de3f;
   int errors = 0, checks = 0, bt, n, w;

   always #2.5 clk = ~clk;

   ufbc_top ufbc_top_inst (.clk(clk), .rstn(rstn), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata_q(rdata_q),
      .receive_pin(rx_line), .external_sync_clock_pin(xck),
      .transmit_pin_q(tx_pin), .transmit_pin_oe_q(tx_oe),
      .receive_pin_owned_q(rx_own));

   ufbc_remote ufbc_remote_inst (.clk(clk), .line_out(rx_line),
      .line_in(tx_pin));

   // ------------------------------------------------------------
   // bus tasks and expectations
   // ------------------------------------------------------------
   task automatic wreg(input logic [2:0] a, input logic [7:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rreg(input logic [2:0] a, output logic [7:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata_q;
   endtask

   task automatic print_verdict;
      $display("errors=%0d checks=%0d", errors, checks);
      if (errors == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   // frame bits lsb first, followed by the next start bit
   function automatic logic [13:0] frame(logic [8:0] v, int nd,
         logic [1:0] par, logic stp);
      logic [13:0] f;
      logic p;
      int k;
      f = '1;
      f[0] = 1'b0;
      p = par[0];
      for (k = 1; k <= nd; k++) begin
         f[k] = v[k-1];
         p = p ^ v[k-1];
      end
      if (par[1]) begin
         f[k] = p;
         k++;
      end
      k = k + 1 + int'(stp);
      f[k] = 1'b0;
      return f;
   endfunction

   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      for (int i = 0; i < 8; i++) begin
         rreg(3'(i), d);
         `CHK(d, rst_v[i])
      end
      wreg(A_BAUD_HI, 8'h03);
      rreg(A_BAUD_HI, d);
      `CHK(d, 8'h03)
      wreg(A_BAUD_HI, 8'h00);
      exp = 14'($random(seed)) & 14'h003e;
      wreg(A_CTRL_C, exp[7:0]);
      rreg(A_CTRL_C, d);
      `CHK(d, exp[7:0])
      // frame per format, all parity codes
      for (int i = 0; i < 5; i++) begin
         w = {$random(seed)} % 3;
         bt = (w + 1) * ((i == 4) ? 8 : 16);
         pc = pcs[i];
         dv[0] = 9'($random(seed));
         dv[1] = 9'($random(seed));
         n = 3 + i + 5 + int'(pc[1]) + i % 2;
         wreg(A_CTRL_A, (i == 4) ? 8'h02 : 8'h00);
         wreg(A_BAUD_LO, 8'(w));
         wreg(A_CTRL_C, {2'h0, pc, 1'(i % 2), szc[i][1:0], 1'b0});
         fork
            ufbc_remote_inst.grab(n, bt, got, ok);
            begin
               wreg(A_CTRL_B, {4'h0, 1'b1, szc[i][2], 1'b0, dv[0][8]});
               wreg(A_DATA, dv[0][7:0]);
               repeat (4) @(posedge clk);
               wreg(A_CTRL_B, {4'h0, 1'b1, szc[i][2], 1'b0, dv[1][8]});
               wreg(A_DATA, dv[1][7:0]);
               wreg(A_CTRL_B, {5'h00, szc[i][2], 2'h0});
            end
         join
         if (ok !== 1'b1) begin
            errors++;
            print_verdict();
         end
         `CHK(got, frame(dv[0], i + 5, pc, 1'(i % 2)))
         `CHK(tx_oe, 1'b1)
         w = 0;
         while (tx_oe !== 1'b0 && w < 8000) begin
            @(posedge clk);
            w++;
         end
         if (w == 8000) begin
            errors++;
            print_verdict();
         end
         `CHK(w > (n - 3) * bt, 1'b1)
         `CHK({tx_oe, tx_pin}, 2'b01)
      end
      rreg(A_CTRL_A, d);
      `CHK(d[6:5], 2'b11)
      wreg(A_CTRL_A, 8'h00);
      wreg(A_BAUD_LO, 8'h00);
      wreg(A_CTRL_B, 8'h10);
      @(posedge clk);
      #1 `CHK(rx_own, 1'b1)
      // parity check, good and bad frames
      for (int i = 0; i < 4; i++) begin
         pc = i[1] ? 2'h3 : 2'h2;
         wreg(A_CTRL_C, {2'h0, pc, 4'h6});
         dv[0] = 9'($random(seed)) & 9'h0ff;
         exp = frame(dv[0], 8, pc, 1'b0) ^ (i[0] ? 14'h0200 : 14'h0000);
         ufbc_remote_inst.send(exp, 11, 16);
         repeat (8) @(posedge clk);
         rreg(A_CTRL_A, d);
         `CHK(d & 8'h9c, {1'b1, 4'h0, i[0], 2'h0})
         rreg(A_CTRL_B, d);
         rreg(A_DATA, d);
         `CHK(d, dv[0][7:0])
      end
      ufbc_remote_inst.send(frame(9'h0c3, 8, 2'h2, 1'b0) ^ 14'h0200, 11, 16);
      repeat (8) @(posedge clk);
      rreg(A_CTRL_A, d);
      `CHK(d[7], 1'b1)
      wreg(A_CTRL_B, 8'h00);
      @(posedge clk);
      #1 `CHK(rx_own, 1'b0)
      rreg(A_CTRL_A, d);
      `CHK(d & 8'h9c, 8'h00)
      rreg(A_DATA, d);
      `CHK(d, 8'h00)
      // reserved and spi modes stay silent
      wreg(A_CTRL_B, 8'h08);
      for (int m = 2; m < 4; m++) begin
         wreg(A_CTRL_C, {2'(m), 6'h06});
         wreg(A_DATA, 8'h55);
         w = 0;
         repeat (200) begin
            @(posedge clk);
            w += int'(tx_pin !== 1'b1);
         end
         `CHK(w, 0)
      end
      // sync mode, polarity zero: change on rising edge only
      wreg(A_CTRL_C, 8'h46);
      exp = frame(9'h055, 8, 2'h0, 1'b0);
      for (int b = 0; b < 10; b++) begin
         repeat (8) @(posedge clk);
         got[b] = tx_pin;
         if (b > 0) `CHK(got[b], d[0])
         xck <= 1'b1;
         repeat (8) @(posedge clk);
         d[0] = tx_pin;
         xck <= 1'b0;
      end
      `CHK(got[9:0], exp[9:0])
      print_verdict();
   end
endmodule // tb_top

`default_nettype wire
